// ### shp_map.svh
// Register offsets, field positions, reset values and timing for the serial host port
`ifndef SHP_MAP_SVH
`define SHP_MAP_SVH
`define SHP_OFS_CLK     2'h0
`define SHP_OFS_CSR     2'h1
`define SHP_OFS_RXD     2'h2
`define SHP_OFS_TXD     2'h3
`define SHP_CK_CPHA     0
`define SHP_CK_CLOCK_POLARITY_BIT     1
`define SHP_CK_HRS      2
`define SHP_CK_DIV_LSB  3
`define SHP_CK_FM_LSB   12
`define SHP_CK_WMASK    24'h003FFF
`define SHP_CK_RST      24'h000001
`define SHP_CS_EN       0
`define SHP_CS_PROT     1
`define SHP_CS_WS_LSB   2
`define SHP_CS_FRZ      4
`define SHP_CS_DEPTH    5
`define SHP_CS_MST      6
`define SHP_CS_TUE      14
`define SHP_CS_TXE      15
`define SHP_CS_RXNE     17
`define SHP_CS_ROE      20
`define SHP_CS_BER      21
`define SHP_CS_BUSY     22
`define SHP_CS_WMASK    24'h00007F
`define SHP_CS_RST      24'h000000
`define SHP_CLK_NS      40
`define SHP_SPIKE_VN_NS 10
`define SHP_SPIKE_N_NS  50
`define SHP_SPIKE_W_NS  100
`define SHP_CYC(ns)     (((ns) + `SHP_CLK_NS - 1) / `SHP_CLK_NS)
`endif

// ### shp_pkg.sv
// Types shared by the serial host port
package shp_pkg;
  typedef enum logic [1:0] {
    FM_BYPASS = 2'h0,
    FM_VNARROW = 2'h1,
    FM_NARROW = 2'h2,
    FM_WIDE = 2'h3
  } shp_fmode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_START = 2'h1,
    ST_SHIFT = 2'h2,
    ST_STOP = 2'h3
  } shp_state_t;
endpackage

// ### shp_port.sv
// Serial host port: SPI / I2C control, spike filters and transfer engine
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "shp_map.svh"

////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RULE1: Two-bit filter mode field in clock control selects four filter modes.
// RULE2: One filter on serial clock input, one on selected data input.
// RULE3: Mode 00 bypasses both filters.
// RULE4: Mode 01 rejects spikes up to 10 ns.
// RULE5: Mode 10 rejects spikes up to 50 ns.
// RULE6: Mode 11 rejects spikes up to 100 ns, for I2C.
// RULE7: Filter mode cleared by reset.
// RULE8: Software waits ten spike widths before enabling after filter changes.
// RULE9: Control bits read/write, status read-only; individual reset clears status only.
// RULE10: Enable bit enables port; clearing gives individual reset; reset clears it.
// RULE11: Individual reset one cycle after clear: inputs inhibited, pins released.
// RULE12: Master clears enable only while busy is low.
// RULE13: Protocol select: 0 SPI, 1 I2C; cleared by reset.
// RULE14: Word size 00/01/10 gives 8/16/24 bits; cleared by reset.
// RULE15: Software changes word size only while not busy.
// RULE16: I2C slave with freeze holds clock low when not ready.
// RULE17: Clock generator set to 0.75 to 1 times external clock.
// RULE18: Without freeze, unready slave flags overrun or underrun.
// RULE19: Depth bit gives one or ten receive levels; cleared by reset.
// RULE20: Master select: 1 master, 0 slave; cleared by reset.
// RULE21: SPI master drives clock; slave select asserted sets bus error.
// RULE22: I2C master generates start, clock pulses and stop.
// RULE23: Filter passes a change after staying stable long enough.
module shp_port #(
  parameter int RX_DEPTH_LO = 1,
  parameter int RX_DEPTH_HI = 10
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  regAddr,
  input  wire logic [23:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [23:0] regRdata,
  input  wire logic        sckIn,
  output logic             sckOut,
  output logic             sckOe,
  input  wire logic        mosiIn,
  output logic             mosiOut,
  output logic             mosiOe,
  input  wire logic        misoIn,
  output logic             misoOut,
  output logic             misoOe,
  input  wire logic        ssInN
);

  // Wide mode needs four samples, so the limit takes three bits
  localparam logic [2:0] LIM_VN = 3'(`SHP_CYC(`SHP_SPIKE_VN_NS) + 1);
  localparam logic [2:0] LIM_N  = 3'(`SHP_CYC(`SHP_SPIKE_N_NS) + 1);
  localparam logic [2:0] LIM_W  = 3'(`SHP_CYC(`SHP_SPIKE_W_NS) + 1);
  localparam logic [3:0] DLO    = 4'(RX_DEPTH_LO);
  localparam logic [3:0] DHI    = 4'(RX_DEPTH_HI);

  function automatic logic [2:0] filtLimit(input logic [1:0] m);
    case (m)
      shp_pkg::FM_VNARROW: filtLimit = LIM_VN; // RULE4
      shp_pkg::FM_NARROW: filtLimit = LIM_N; // RULE5
      shp_pkg::FM_WIDE: filtLimit = LIM_W; // RULE6
      default: filtLimit = 3'h0;
    endcase
  endfunction

  function automatic logic [4:0] lastBit(input logic [1:0] ws);
    case (ws)
      2'h1: lastBit = 5'h0F;
      2'h2: lastBit = 5'h17;
      default: lastBit = 5'h07;
    endcase
  endfunction

  // Received bits gather at the bottom; move them to the top of the word
  function automatic logic [23:0] alignRx(input logic [1:0] ws, input logic [23:0] s);
    case (ws)
      2'h1: alignRx = {s[15:0], 8'h00};
      2'h2: alignRx = s;
      default: alignRx = {s[7:0], 16'h0000};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [13:0] ckReg_q;
  logic [6:0]  csCtl_q;
  logic        enDly_q;
  logic        berr_q;
  logic        roe_q;
  logic        tue_q;
  logic [23:0] txHold_q;
  logic        txFull_q;
  logic [23:0] fifo_q [RX_DEPTH_HI];
  logic [3:0]  wrPtr_q;
  logic [3:0]  rdPtr_q;
  logic [3:0]  rxCnt_q;
  logic [3:0]  syncA_q;
  logic [3:0]  syncB_q;
  logic [1:0]  filt_q;
  logic [1:0]  fCnt_q [2];
  logic        sckPrev_q;
  logic        datPrev_q;
  shp_pkg::shp_state_t state_q;
  logic [10:0] divCnt_q;
  logic        ph_q;
  logic [4:0]  bitCnt_q;
  logic [23:0] txSh_q;
  logic [23:0] rxSh_q;
  logic        sdaDrv_q;
  logic        slvLd_q;
  logic        push_q;
  logic [23:0] pushData_q;

  logic        indiv;
  logic        clock_polarity_bit;
  logic [1:0]  fmode;
  logic        i2c;
  logic        mst;
  logic        frz;
  logic [1:0]  ws;
  logic [3:0]  depth;
  logic        rxFull;
  logic        pop;
  logic [1:0]  rawIn;
  logic [1:0]  fIn;
  logic        sckF;
  logic        datF;
  logic        sampleEdge;
  logic        shiftEdge;
  logic        startCond;
  logic        tick;
  logic        busy;
  logic        sclHold;
  logic        slvTue;
  logic        slvRoe;

  assign clock_polarity_bit  = ckReg_q[`SHP_CK_CLOCK_POLARITY_BIT];
  assign fmode = ckReg_q[`SHP_CK_FM_LSB +: 2]; // RULE1
  assign i2c   = csCtl_q[`SHP_CS_PROT]; // RULE13
  assign mst   = csCtl_q[`SHP_CS_MST]; // RULE20
  assign frz   = csCtl_q[`SHP_CS_FRZ] & i2c & ~mst; // RULE18
  assign ws    = csCtl_q[`SHP_CS_WS_LSB +: 2]; // RULE14
  assign depth = csCtl_q[`SHP_CS_DEPTH] ? DHI : DLO; // RULE19
  assign indiv = ~enDly_q; // RULE11
  assign rxFull = rxCnt_q == depth;
  assign pop   = regRd && regAddr == `SHP_OFS_RXD && rxCnt_q != 4'h0;
  assign busy  = state_q != shp_pkg::ST_IDLE || (!mst && bitCnt_q != 5'h00);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ckReg_q <= 14'(`SHP_CK_RST); // RULE7
      csCtl_q <= 7'(`SHP_CS_RST); // RULE10
    end
    else if (regWr && regAddr == `SHP_OFS_CLK)
    begin
      ckReg_q <= 14'(regWdata & `SHP_CK_WMASK); // RULE1
    end
    else if (regWr && regAddr == `SHP_OFS_CSR)
    begin
      csCtl_q <= 7'(regWdata & `SHP_CS_WMASK); // RULE9
    end
  end

  // Enable takes hold one cycle after the control bit
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      enDly_q <= 1'b0;
    end
    else
    begin
      enDly_q <= csCtl_q[`SHP_CS_EN]; // RULE10
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      regRdata <= 24'h000000;
    end
    else if (regRd)
    begin
      case (regAddr)
        `SHP_OFS_CLK: regRdata <= {10'h000, ckReg_q};
        `SHP_OFS_CSR: regRdata <= {1'b0, busy, berr_q, roe_q, 2'h0, rxCnt_q != 4'h0, 1'b0,
                                   ~txFull_q, tue_q, 7'h00, csCtl_q}; // RULE9
        `SHP_OFS_RXD: regRdata <= rxCnt_q != 4'h0 ? fifo_q[rdPtr_q] : 24'h000000;
        default: regRdata <= 24'h000000;
      endcase
    end
    else
    begin
      regRdata <= 24'h000000;
    end
  end

  // Status flags: a clear wins over an event in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || indiv)
    begin
      berr_q <= 1'b0; // RULE9
      roe_q <= 1'b0;
      tue_q <= 1'b0;
    end
    else
    begin
      if (i2c == 1'b0 && mst && !syncB_q[3])
      begin
        berr_q <= 1'b1; // RULE21
      end
      if (slvRoe)
      begin
        roe_q <= 1'b1; // RULE18
      end
      if (slvTue)
      begin
        tue_q <= 1'b1; // RULE18
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive FIFO, depth chosen at run time
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || indiv)
    begin
      wrPtr_q <= 4'h0;
      rdPtr_q <= 4'h0;
      rxCnt_q <= 4'h0;
    end
    else
    begin
      if (push_q && !rxFull)
      begin
        fifo_q[wrPtr_q] <= pushData_q;
        wrPtr_q <= wrPtr_q == DHI - 4'h1 ? 4'h0 : wrPtr_q + 4'h1;
      end
      if (pop)
      begin
        rdPtr_q <= rdPtr_q == DHI - 4'h1 ? 4'h0 : rdPtr_q + 4'h1;
      end
      rxCnt_q <= rxCnt_q + 4'(push_q && !rxFull) - 4'(pop); // RULE19
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers, then spike filters
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      syncA_q <= 4'hF;
      syncB_q <= 4'hF;
    end
    else
    begin
      syncA_q <= {ssInN, misoIn, mosiIn, sckIn};
      syncB_q <= syncA_q;
    end
  end

  // Inputs inhibited in individual reset: held at idle
  assign rawIn[0] = indiv ? ~i2c & clock_polarity_bit | i2c : syncB_q[0]; // RULE11
  assign rawIn[1] = indiv ? 1'b1 : (!i2c && mst) ? syncB_q[2] : syncB_q[1]; // RULE2

  for (genvar g = 0; g < 2; g++)
  begin : gFilt
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
      begin
        filt_q[g] <= 1'b1;
        fCnt_q[g] <= 2'h0;
      end
      else if (rawIn[g] == filt_q[g])
      begin
        fCnt_q[g] <= 2'h0;
      end
      else if ({1'b0, fCnt_q[g]} + 3'h1 >= filtLimit(fmode))
      begin
        filt_q[g] <= rawIn[g]; // RULE23
        fCnt_q[g] <= 2'h0;
      end
      else
      begin
        fCnt_q[g] <= fCnt_q[g] + 2'h1;
      end
    end
    // Bypass costs no latency, so the fastest bit rates stay usable
    assign fIn[g] = fmode == shp_pkg::FM_BYPASS ? rawIn[g] : filt_q[g]; // RULE3
  end

  assign sckF = fIn[0];
  assign datF = fIn[1];

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sckPrev_q <= 1'b1;
      datPrev_q <= 1'b1;
    end
    else
    begin
      sckPrev_q <= sckF;
      datPrev_q <= datF;
    end
  end

  assign sampleEdge = sckF != sckPrev_q && (i2c ? sckF : sckF != clock_polarity_bit);
  assign shiftEdge  = sckF != sckPrev_q && !(i2c ? sckF : sckF != clock_polarity_bit);
  assign startCond  = i2c && sckF && sckPrev_q && datPrev_q && !datF;
  assign tick       = divCnt_q == 11'h000;
  assign slvTue = !mst && sampleEdge && bitCnt_q == 5'h00 && !slvLd_q && !frz;
  assign slvRoe = !mst && sampleEdge && bitCnt_q == lastBit(ws) && rxFull && !frz;
  // Without R/W decoding, freeze covers either not-ready case
  assign sclHold = frz && enDly_q && bitCnt_q == 5'h00 && !sckF && (rxFull || (!txFull_q && !slvLd_q)); // RULE16

  ////////////////////////////////////////////////////////////////////////
  // Transfer engine, master and slave
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || indiv)
    begin
      state_q <= shp_pkg::ST_IDLE; // RULE11
      divCnt_q <= 11'h000;
      ph_q <= 1'b0;
      bitCnt_q <= 5'h00;
      txSh_q <= 24'h000000;
      rxSh_q <= 24'h000000;
      sdaDrv_q <= 1'b1;
      slvLd_q <= 1'b0;
      push_q <= 1'b0;
      pushData_q <= 24'h000000;
      txHold_q <= 24'h000000;
      txFull_q <= 1'b0;
    end
    else
    begin
      push_q <= 1'b0;
      if (regWr && regAddr == `SHP_OFS_TXD)
      begin
        txHold_q <= regWdata;
        txFull_q <= 1'b1;
      end
      divCnt_q <= tick ? (ckReg_q[`SHP_CK_HRS] ? {3'h0, ckReg_q[10:3]} : {ckReg_q[10:3], 3'h7})
                       : divCnt_q - 11'h001;
      if (mst)
      begin
        case (state_q)
          shp_pkg::ST_IDLE:
          begin
            ph_q <= 1'b0;
            sdaDrv_q <= 1'b1;
            if (txFull_q && tick)
            begin
              txSh_q <= txHold_q;
              txFull_q <= 1'b0;
              bitCnt_q <= 5'h00;
              state_q <= i2c ? shp_pkg::ST_START : shp_pkg::ST_SHIFT;
            end
          end
          shp_pkg::ST_START:
          begin
            sdaDrv_q <= 1'b0; // RULE22
            if (tick)
            begin
              state_q <= shp_pkg::ST_SHIFT;
            end
          end
          shp_pkg::ST_SHIFT:
          begin
            // Data line let go only once the clock is already low
            if (!ph_q)
            begin
              sdaDrv_q <= 1'b1;
            end
            if (tick && !ph_q)
            begin
              ph_q <= 1'b1; // RULE21
              rxSh_q <= {rxSh_q[22:0], datF};
            end
            else if (tick)
            begin
              ph_q <= 1'b0;
              txSh_q <= {txSh_q[22:0], 1'b0};
              bitCnt_q <= bitCnt_q + 5'h01;
              if (bitCnt_q == lastBit(ws))
              begin
                push_q <= 1'b1;
                pushData_q <= alignRx(ws, rxSh_q);
                bitCnt_q <= 5'h00;
                sdaDrv_q <= 1'b0;
                state_q <= i2c ? shp_pkg::ST_STOP : shp_pkg::ST_IDLE;
              end
            end
          end
          shp_pkg::ST_STOP:
          begin
            ph_q <= 1'b1; // RULE22
            if (tick)
            begin
              sdaDrv_q <= 1'b1;
              state_q <= shp_pkg::ST_IDLE;
            end
          end
          default: state_q <= shp_pkg::ST_IDLE;
        endcase
      end
      else if ((!i2c && syncB_q[3]) || startCond)
      begin
        bitCnt_q <= 5'h00;
      end
      else
      begin
        if (bitCnt_q == 5'h00 && !slvLd_q && txFull_q)
        begin
          txSh_q <= txHold_q;
          txFull_q <= 1'b0;
          slvLd_q <= 1'b1;
        end
        if (sampleEdge)
        begin
          rxSh_q <= {rxSh_q[22:0], datF};
          bitCnt_q <= bitCnt_q + 5'h01;
          if (bitCnt_q == lastBit(ws))
          begin
            push_q <= !rxFull; // RULE18
            pushData_q <= alignRx(ws, {rxSh_q[22:0], datF});
            bitCnt_q <= 5'h00;
            slvLd_q <= 1'b0;
          end
        end
        else if (shiftEdge)
        begin
          txSh_q <= {txSh_q[22:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive; all released in individual reset
  always_comb
  begin
    sckOut = 1'b0;
    sckOe = 1'b0;
    mosiOut = 1'b0;
    mosiOe = 1'b0;
    misoOut = txSh_q[23];
    misoOe = 1'b0;
    if (enDly_q && i2c)
    begin
      sckOe = (mst && (state_q == shp_pkg::ST_SHIFT || state_q == shp_pkg::ST_STOP) && !ph_q) || sclHold; // RULE16
      mosiOe = mst ? !sdaDrv_q || (state_q == shp_pkg::ST_SHIFT && !txSh_q[23]) : 1'b0;
    end
    else if (enDly_q && mst)
    begin
      sckOut = clock_polarity_bit ^ ph_q; // RULE21
      sckOe = 1'b1;
      mosiOut = txSh_q[23];
      mosiOe = 1'b1;
    end
    else if (enDly_q)
    begin
      misoOe = !syncB_q[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_filter_bypass: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE3
    fmode == 2'h0 |-> sckF == rawIn[0] && datF == rawIn[1])
    else $error("bypass filter not transparent");
  a_filter_spike: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE23
    $past(fmode, 1) != 2'h0 && $changed(filt_q[0]) |-> $past(rawIn[0], 2) == filt_q[0])
    else $error("filter passed a one-sample spike");
  a_filter_reset: assert property (@(posedge core_clk) // RULE7
    !rst_n |=> fmode == 2'h0 && csCtl_q == 7'h00)
    else $error("config not cleared by reset");
  a_enable_delay: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE11
    $fell(csCtl_q[0]) |-> !indiv ##1 indiv)
    else $error("individual reset not one cycle late");
  a_pins_released: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE11
    indiv |-> !sckOe && !mosiOe && !misoOe)
    else $error("pin driven in individual reset");
  a_status_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE9
    indiv && !(regWr && regAddr == `SHP_OFS_CSR) |=> !berr_q && rxCnt_q == 4'h0 && $stable(csCtl_q))
    else $error("status not cleared");
  a_spi_berr: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE21
    !indiv && !i2c && mst && !syncB_q[3] |=> berr_q)
    else $error("bus error flag not set");
  a_rx_depth: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE19
    rxCnt_q <= depth)
    else $error("receive count beyond depth");
  a_freeze_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE16
    sckOe && i2c && !mst |-> frz && (rxFull || (!txFull_q && !slvLd_q)))
    else $error("clock held without freeze cause");

endmodule

// ### shp_peer.sv
// Behavioural SPI peer on the far side of the serial host port pins
`timescale 1ns/1ns

module shp_peer (
  input  wire logic clk,
  input  wire logic sckLine,
  input  wire logic mosiLine,
  output logic      sckDrv,
  output logic      mosiDrv,
  output logic      misoDrv,
  output logic      ssN
);
  logic [23:0] misoWord = 24'h000000;
  logic [23:0] cap      = 24'h000000;
  logic        slaveOn  = 1'b0;
  int          edges    = 0;

  initial
  begin
    sckDrv  = 1'b0;
    mosiDrv = 1'b0;
    misoDrv = 1'b0;
    ssN     = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Slave role, CLOCK_POLARITY_BIT 0: sample on rise, shift on fall
  always @(posedge sckLine)
    if (slaveOn)
    begin
      cap = {cap[22:0], mosiLine};
      edges++;
    end

  always @(negedge sckLine)
    if (slaveOn && edges < 24)
      misoDrv = misoWord[23 - edges];

  task automatic arm(input logic [23:0] w);
    misoWord = w;
    cap      = 24'h000000;
    edges    = 0;
    misoDrv  = w[23];
    slaveOn  = 1'b1;
  endtask

  // Released line shows the inverse, never the last bit
  task automatic disarm();
    slaveOn = 1'b0;
    misoDrv = ~misoDrv;
  endtask

  task automatic select(input logic v);
    ssN = v;
  endtask

  // I2C: a high drive pulls the open-drain clock line low
  task automatic pull_scl(input logic v);
    sckDrv = v;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Master role: optional clock spike, then one word MSB first
  task automatic send_word(input logic [23:0] w, input int n, input int spikeW, input logic spikeBit);
    ssN     = 1'b0;
    mosiDrv = spikeBit;
    #100;
    @(posedge clk);
    // Spike placed across one or two sampling edges
    #(spikeW == 10 ? 35 : 20);
    sckDrv = 1'b1;
    #(spikeW);
    sckDrv = 1'b0;
    #200;
    for (int i = 0; i < n; i++)
    begin
      mosiDrv = w[23 - i];
      #160;
      sckDrv = 1'b1;
      #160;
      sckDrv = 1'b0;
    end
    #100;
    mosiDrv = ~mosiDrv;
    ssN     = 1'b1;
  endtask
endmodule

// ### testbench.sv
// Self-checking bench for the serial host port
`timescale 1ns/1ns
`include "shp_map.svh"

module testbench;
  logic        core_clk  = 1'b0;
  logic        rst_n     = 1'b0;
  logic [1:0]  regAddr   = 2'h0;
  logic [23:0] regWdata  = 24'h000000;
  logic        regWr     = 1'b0;
  logic        regRd     = 1'b0;
  logic        i2cMode   = 1'b0;
  logic [23:0] regRdata;
  logic [23:0] rdv;
  wire         sckIn;
  wire         mosiIn;
  wire         misoIn;
  wire         ssInN;
  wire         sckOut;
  wire         sckOe;
  wire         mosiOut;
  wire         mosiOe;
  wire         misoOut;
  wire         misoOe;
  wire         peerSck;
  wire         peerMosi;
  wire         peerMiso;
  int          n_mismatch = 0;
  int          checks     = 0;
  int          nb;
  int          spikeW [4] = '{10, 10, 40, 80};

  // Open drain with pull-up in I2C, push-pull in SPI
  assign sckIn  = i2cMode ? ~(sckOe | peerSck) : (sckOe ? sckOut : peerSck);
  assign mosiIn = i2cMode ? ~mosiOe : (mosiOe ? mosiOut : peerMosi);
  assign misoIn = misoOe ? misoOut : peerMiso;

  shp_port u_shp_port (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .regAddr  (regAddr),
    .regWdata (regWdata),
    .regWr    (regWr),
    .regRd    (regRd),
    .regRdata (regRdata),
    .sckIn    (sckIn),
    .sckOut   (sckOut),
    .sckOe    (sckOe),
    .mosiIn   (mosiIn),
    .mosiOut  (mosiOut),
    .mosiOe   (mosiOe),
    .misoIn   (misoIn),
    .misoOut  (misoOut),
    .misoOe   (misoOe),
    .ssInN    (ssInN)
  );

  shp_peer u_shp_peer (
    .clk      (core_clk),
    .sckLine  (sckIn),
    .mosiLine (mosiIn),
    .sckDrv   (peerSck),
    .mosiDrv  (peerMosi),
    .misoDrv  (peerMiso),
    .ssN      (ssInN)
  );

  always #20 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [1:0] a, input logic [23:0] d);
    @(posedge core_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge core_clk);
    regWr    <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [23:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd   <= 1'b0;
    @(negedge core_clk);
    d = regRdata;
  endtask

  // Busy polled through the register port, bounded
  task automatic wait_idle();
    for (int i = 0; i < 400; i++)
    begin
      rd(`SHP_OFS_CSR, rdv);
      if (rdv[`SHP_CS_BUSY] === 1'b0)
        return;
    end
    n_mismatch++;
    final_report();
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #3000000;
    n_mismatch++;
    final_report();
  end

  initial
  begin
    do_reset();
    rd(`SHP_OFS_CLK, rdv);
    check("clk reset", rdv, `SHP_CK_RST);
    rd(`SHP_OFS_CSR, rdv);
    check("csr reset", rdv & 24'h70007F, 24'h000000);
    check("oe reset", {21'h0, sckOe, mosiOe, misoOe}, 24'h000000);
    // Status bits must ignore writes
    wr(`SHP_OFS_CLK, 24'hFFFFFF);
    wr(`SHP_OFS_CSR, 24'hFFFFFE);
    rd(`SHP_OFS_CLK, rdv);
    check("clk fields", rdv, 24'h003FFF);
    rd(`SHP_OFS_CSR, rdv);
    check("csr fields", rdv & 24'h70407F, 24'h00007E);
    do_reset();
    rd(`SHP_OFS_CLK, rdv);
    check("clk rereset", rdv, `SHP_CK_RST);
    rd(`SHP_OFS_CSR, rdv);
    check("csr rereset", rdv & 24'h00007F, 24'h000000);

    // Clock spike then one slave word, per filter mode
    for (int m = 0; m < 4; m++)
    begin
      wr(`SHP_OFS_CSR, 24'h000000);
      wr(`SHP_OFS_CLK, 24'(m << `SHP_CK_FM_LSB) | 24'h000001);
      repeat (30) @(posedge core_clk);
      wr(`SHP_OFS_CSR, 24'h000001);
      u_shp_peer.send_word(24'h5A0000, 8, spikeW[m], 1'b1);
      repeat (4) @(posedge core_clk);
      rd(`SHP_OFS_RXD, rdv);
      check("rx after spike", rdv & 24'hFF0000, m == 0 ? 24'hAD0000 : 24'h5A0000);
    end

    // SPI master, all word sizes
    wr(`SHP_OFS_CSR, 24'h000000);
    wr(`SHP_OFS_CLK, 24'h00003D);
    for (int ws = 0; ws < 3; ws++)
    begin
      nb = 8 * (ws + 1);
      wr(`SHP_OFS_CSR, 24'h000041 | 24'(ws << `SHP_CS_WS_LSB));
      u_shp_peer.arm(24'h96A55A);
      wr(`SHP_OFS_TXD, 24'hC33C5A);
      repeat (20) @(posedge core_clk);
      check("sck drive", {23'h0, sckOe}, 24'h000001);
      wait_idle();
      check("sck pulses", 24'(u_shp_peer.edges), 24'(nb));
      check("mosi word", u_shp_peer.cap, 24'hC33C5A >> (24 - nb));
      check("sck idle", {23'h0, sckOut}, 24'h000000);
      rd(`SHP_OFS_RXD, rdv);
      check("rx word", rdv, 24'h96A55A & ~(24'hFFFFFF >> nb));
      u_shp_peer.disarm();
    end

    // Select asserted while master, then individual reset
    u_shp_peer.select(1'b0);
    repeat (4) @(posedge core_clk);
    rd(`SHP_OFS_CSR, rdv);
    check("bus error", rdv & 24'h20007F, 24'h200049);
    u_shp_peer.select(1'b1);
    wr(`SHP_OFS_CSR, 24'h000048);
    repeat (2) @(posedge core_clk);
    rd(`SHP_OFS_CSR, rdv);
    check("indiv reset", rdv & 24'h70407F, 24'h000048);
    check("pins released", {21'h0, sckOe, mosiOe, misoOe}, 24'h000000);

    // I2C master: start with SCL released, all released after stop
    @(posedge core_clk);
    i2cMode <= 1'b1;
    wr(`SHP_OFS_CSR, 24'h000043);
    wr(`SHP_OFS_TXD, 24'hA50000);
    for (int t = 0; t < 200 && mosiOe !== 1'b1; t++)
      @(negedge core_clk);
    check("start cond", {22'h0, mosiOe, sckOe}, 24'h000002);
    wait_idle();
    check("stop release", {22'h0, mosiOe, sckOe}, 24'h000000);

    // I2C slave with freeze: clock held low until a word is loaded
    wr(`SHP_OFS_CSR, 24'h000012);
    wr(`SHP_OFS_CLK, 24'h00001D);
    wr(`SHP_OFS_CSR, 24'h000013);
    @(negedge core_clk);
    u_shp_peer.pull_scl(1'b1);
    repeat (6) @(negedge core_clk);
    u_shp_peer.pull_scl(1'b0);
    repeat (4) @(negedge core_clk);
    check("scl held", {23'h0, sckOe}, 24'h000001);
    wr(`SHP_OFS_TXD, 24'h5A0000);
    repeat (4) @(negedge core_clk);
    check("scl freed", {23'h0, sckOe}, 24'h000000);
    final_report();
  end
endmodule
